// ### design/dgp_top.sv
// Dual GPIO port with an AXI4-Lite register slave.
`timescale 1ns/100ps
module dgp_top (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [dgp_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic [2:0] s_axi_awprot_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [dgp_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic [2:0] s_axi_arprot_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	input wire logic [5:0] pa_in_i,
	output logic [5:0] pa_out_o,
	output logic [5:0] pa_oe_o,
	output logic [5:0] pa_pullup_o,
	input wire logic [7:0] pb_in_i,
	output logic [7:0] pb_out_o,
	output logic [7:0] pb_oe_o,
	output logic [7:0] pb_pullup_o,
	input wire logic quad_bus_clock_i,
	input wire logic [5:0] keypad_irq_enables_i,
	output logic [5:0] keypad_interrupt_o
);
	import dgp_pkg::*;

	// ------------------------------------------------------------------
	// Reset release and state.
	// ------------------------------------------------------------------
	logic rst_meta;
	logic rst_q;
	dgp_ctl_s q;
	dgp_ctl_s next_q;
	dgp_lat_s l;
	dgp_lat_s next_l;
	logic wr_go;
	logic osc_drive;
	logic [5:0] pa_rd;
	logic [7:0] pb_rd;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == '0) && (a[5:2] <= IDX_CFG);
	endfunction : reg_hit

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_q <= rst_meta;
		end
	end

	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_l = l;
		wr_go = q.aw_held && q.w_held && !q.bvalid;
		// Pins pass two flip-flops before any logic reads them.
		next_q.sa1 = pa_in_i;
		next_q.sa2 = q.sa1;
		next_q.sb1 = pb_in_i;
		next_q.sb2 = q.sb1;
		next_q.qc1 = quad_bus_clock_i;
		next_q.qc2 = q.qc1;
		// Readback mixes latch and pin per direction bit.
		pa_rd = (l.lat_a & q.dir_a & PA_DATA_MASK) | (q.sa2 & ~q.dir_a & PA_DATA_MASK);
		pa_rd[PA_IN_ONLY_BIT] = q.cfg_irq ? 1'b0 : q.sa2[PA_IN_ONLY_BIT];
		pb_rd = (l.lat_b & q.dir_b) | (q.sb2 & ~q.dir_b);

		// Write path: address and data are taken in either order.
		if (s_axi_awvalid_i && q.awready) begin
			next_q.aw_held = 1'b1;
			next_q.awaddr = s_axi_awaddr_i;
			next_q.awready = 1'b0;
		end
		if (s_axi_wvalid_i && q.wready) begin
			next_q.w_held = 1'b1;
			next_q.wdata = s_axi_wdata_i[7:0];
			next_q.wstrb0 = s_axi_wstrb_i[0];
			next_q.wready = 1'b0;
		end
		if (wr_go) begin
			next_q.aw_held = 1'b0;
			next_q.w_held = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp = reg_hit(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (reg_hit(q.awaddr) && q.wstrb0) begin
				case (q.awaddr[5:2])
					IDX_PA: next_l.lat_a = q.wdata[5:0] & PA_DATA_MASK;
					IDX_PB: next_l.lat_b = q.wdata;
					IDX_DIR_A: next_q.dir_a = q.wdata[5:0];
					IDX_DIR_B: next_q.dir_b = q.wdata;
					IDX_PUE_A: begin
						next_q.pue_a = q.wdata[5:0];
						next_q.osc_en = q.wdata[OSC_EN_BIT];
					end
					IDX_PUE_B: next_q.pue_b = q.wdata;
					IDX_CFG: begin
						next_q.cfg_osc = q.wdata[1:0];
						next_q.cfg_irq = q.wdata[CFG_IRQ_BIT];
					end
					default: begin
					end
				endcase
			end
		end
		if (q.bvalid && s_axi_bready_i) begin
			next_q.bvalid = 1'b0;
			next_q.awready = 1'b1;
			next_q.wready = 1'b1;
		end

		// Read path: one read outstanding, answered on the next edge.
		if (s_axi_arvalid_i && q.arready) begin
			next_q.arready = 1'b0;
			next_q.rvalid = 1'b1;
			next_q.rresp = reg_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			case (reg_hit(s_axi_araddr_i) ? s_axi_araddr_i[5:2] : 4'hF)
				IDX_PA: next_q.rdata = {2'h0, pa_rd};
				IDX_PB: next_q.rdata = pb_rd;
				IDX_DIR_A: next_q.rdata = {2'h0, q.dir_a};
				IDX_DIR_B: next_q.rdata = q.dir_b;
				IDX_PUE_A: next_q.rdata = {q.osc_en, 1'b0, q.pue_a};
				IDX_PUE_B: next_q.rdata = q.pue_b;
				IDX_CFG: next_q.rdata = {5'h00, q.cfg_irq, q.cfg_osc};
				default: next_q.rdata = 8'h00;
			endcase
		end
		if (q.rvalid && s_axi_rready_i) begin
			next_q.rvalid = 1'b0;
			next_q.arready = 1'b1;
		end

		// Pin drivers follow the registers of the same edge.
		// Driven data is masked by the enable, so an undriven pin outputs 0 even with a never-written latch.
		osc_drive = next_q.osc_en && (next_q.cfg_osc == OSC_INT || next_q.cfg_osc == OSC_RC);
		next_q.pa_oe = next_q.dir_a & PA_DATA_MASK;
		next_q.pa_out = next_l.lat_a & next_q.pa_oe;
		next_q.pa_pu = next_q.pue_a & ~next_q.dir_a;
		next_q.keypad_interrupt = q.sa2 & keypad_irq_enables_i;
		if (osc_drive) begin
			next_q.pa_oe[PA_SHARED_BIT] = 1'b1;
			next_q.pa_out[PA_SHARED_BIT] = q.qc2;
			next_q.pa_pu[PA_SHARED_BIT] = 1'b0;
			next_q.keypad_interrupt[PA_SHARED_BIT] = 1'b0;
		end
		next_q.pb_oe = next_q.dir_b;
		next_q.pb_out = next_l.lat_b & next_q.pb_oe;
		next_q.pb_pu = next_q.pue_b & ~next_q.dir_b;
	end

	// ------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_q) begin
		if (!rst_q) begin
			q <= '0;
			q.dir_a <= DIR_A_RST;
			q.dir_b <= DIR_B_RST;
			q.pue_a <= PUE_A_RST;
			q.pue_b <= PUE_B_RST;
			q.cfg_osc <= CFG_OSC_RST;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Latches have no reset so their contents survive one.
	always_ff @(posedge mclk_i) begin
		l <= next_l;
	end

	// ------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------
	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rvalid_o = q.rvalid;
	assign s_axi_rdata_o = {24'h000000, q.rdata};
	assign s_axi_rresp_o = q.rresp;
	assign pa_out_o = q.pa_out;
	assign pa_oe_o = q.pa_oe;
	assign pa_pullup_o = q.pa_pu;
	assign pb_out_o = q.pb_out;
	assign pb_oe_o = q.pb_oe;
	assign pb_pullup_o = q.pb_pu;
	assign keypad_interrupt_o = q.keypad_interrupt;

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_q);

	property p_dir_a_reset;
		$rose(rst_q) |-> (q.dir_a == 6'h00) && (pa_oe_o == 6'h00);
	endproperty
	a_dir_a_reset: assert property (p_dir_a_reset) else $error("Port A not input after reset.");

	property p_dir_b_reset;
		$rose(rst_q) |-> (q.dir_b == 8'h00) && (pb_oe_o == 8'h00);
	endproperty
	a_dir_b_reset: assert property (p_dir_b_reset) else $error("Port B not input after reset.");

	property p_b_drive;
		pb_oe_o == q.dir_b;
	endproperty
	a_b_drive: assert property (p_b_drive) else $error("Port B driver disagrees with direction.");

	property p_in_only;
		!pa_oe_o[PA_IN_ONLY_BIT];
	endproperty
	a_in_only: assert property (p_in_only) else $error("Input-only pin driven.");

	property p_pull_off;
		((pa_pullup_o & pa_oe_o) == 6'h00) && ((pb_pullup_o & pb_oe_o) == 8'h00);
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("Pullup on while driving.");

	property p_pull_b;
		pb_pullup_o == (q.pue_b & ~q.dir_b);
	endproperty
	a_pull_b: assert property (p_pull_b) else $error("Port B pullup wrong.");

	property p_osc_out;
		q.osc_en && (q.cfg_osc == OSC_XTAL || q.cfg_osc == OSC_EXT) |->
			pa_oe_o[PA_SHARED_BIT] == q.dir_a[PA_SHARED_BIT];
	endproperty
	a_osc_out: assert property (p_osc_out) else $error("Clock-out acted under crystal option.");

	property p_osc_on;
		q.osc_en && (q.cfg_osc == OSC_INT || q.cfg_osc == OSC_RC) |->
			pa_oe_o[PA_SHARED_BIT] && !pa_pullup_o[PA_SHARED_BIT];
	endproperty
	a_osc_on: assert property (p_osc_on) else $error("Clock-out not driven.");

	property p_b_write;
		wr_go && q.wstrb0 && q.awaddr == {2'h0, IDX_PB, 2'h0} |=> l.lat_b == $past(q.wdata);
	endproperty
	a_b_write: assert property (p_b_write) else $error("Port B latch missed a write.");

	property p_b_hold;
		!wr_go |=> $stable(l.lat_b) && $stable(l.lat_a);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("Latch changed without a write.");

	property p_b_read;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == {2'h0, IDX_PB, 2'h0} |=>
			s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(pb_rd);
	endproperty
	a_b_read: assert property (p_b_read) else $error("Port B read value wrong.");

	property p_a_bit2;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == {2'h0, IDX_PA, 2'h0} && q.cfg_irq |=>
			!s_axi_rdata_o[PA_IN_ONLY_BIT] && s_axi_rdata_o[7:6] == 2'h0;
	endproperty
	a_a_bit2: assert property (p_a_bit2) else $error("Port A bit 2 not masked.");

	property p_b_resp;
		q.aw_held && q.w_held |-> ##[0:1] s_axi_bvalid_o;
	endproperty
	a_b_resp: assert property (p_b_resp) else $error("Write response late.");

	// ------------------------------------------------------------------
	// Pin-side checks.
	// ------------------------------------------------------------------
	// Port A drive, pullup and keypad checks step aside on every pin while the clock-out enable is set, whatever the clock option.
	property p_a_drive;
		!q.osc_en |-> pa_oe_o == (q.dir_a & PA_DATA_MASK);
	endproperty
	a_a_drive: assert property (p_a_drive) else $error("Port A driver disagrees with direction.");

	property p_a_out;
		!q.osc_en |-> pa_out_o == (l.lat_a & pa_oe_o);
	endproperty
	a_a_out: assert property (p_a_out) else $error("Port A drive value wrong.");

	property p_b_out;
		pb_out_o == (l.lat_b & pb_oe_o);
	endproperty
	a_b_out: assert property (p_b_out) else $error("Port B drive value wrong.");

	property p_pull_a;
		!q.osc_en |-> pa_pullup_o == (q.pue_a & ~q.dir_a);
	endproperty
	a_pull_a: assert property (p_pull_a) else $error("Port A pullup wrong.");

	property p_a_read;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == {2'h0, IDX_PA, 2'h0} |=>
			(s_axi_rdata_o[5:0] & PA_DATA_MASK) == $past(((l.lat_a & q.dir_a) | (q.sa2 & ~q.dir_a)) & PA_DATA_MASK);
	endproperty
	a_a_read: assert property (p_a_read) else $error("Port A read value wrong.");

	property p_a_pin2;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == {2'h0, IDX_PA, 2'h0} && !q.cfg_irq |=>
			s_axi_rdata_o[PA_IN_ONLY_BIT] == $past(q.sa2[PA_IN_ONLY_BIT]);
	endproperty
	a_a_pin2: assert property (p_a_pin2) else $error("Port A bit 2 not the pin level.");

	property p_lat_bit2;
		wr_go && q.wstrb0 && q.awaddr == {2'h0, IDX_PA, 2'h0} |=> !l.lat_a[PA_IN_ONLY_BIT];
	endproperty
	a_lat_bit2: assert property (p_lat_bit2) else $error("Port A latch stored bit 2.");

	property p_no_strobe;
		wr_go && !q.wstrb0 |=> $stable(l.lat_a) && $stable(l.lat_b);
	endproperty
	a_no_strobe: assert property (p_no_strobe) else $error("Latch changed without a byte strobe.");

	property p_kbi;
		!q.osc_en |-> keypad_interrupt_o == ($past(q.sa2) & $past(keypad_irq_enables_i));
	endproperty
	a_kbi: assert property (p_kbi) else $error("Keypad interrupt line wrong.");

	property p_osc_pin;
		q.osc_en && (q.cfg_osc == OSC_INT || q.cfg_osc == OSC_RC) |->
			pa_out_o[PA_SHARED_BIT] == $past(q.qc2) && !keypad_interrupt_o[PA_SHARED_BIT];
	endproperty
	a_osc_pin: assert property (p_osc_pin) else $error("Clock-out pin carries the wrong level.");

	// ------------------------------------------------------------------
	// Bus handshake checks.
	// ------------------------------------------------------------------
	property p_r_answer;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("Read answer late.");

	property p_r_done;
		s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
	endproperty
	a_r_done: assert property (p_r_done) else $error("Read not closed after its handshake.");

	property p_b_done;
		s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
	endproperty
	a_b_done: assert property (p_b_done) else $error("Write not closed after its handshake.");

	property p_err_zero;
		s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR |-> s_axi_rdata_o == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("Refused read returned data.");

	c_write: cover property (s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == RESP_OKAY);
	c_read_in: cover property (s_axi_rvalid_o && q.dir_b != 8'h00 && q.dir_b != 8'hFF);
	c_osc: cover property (q.osc_en && q.cfg_osc == OSC_RC);
	c_bad: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);

endmodule : dgp_top

// ### pkg/dgp_pkg.sv
// Register map, field layout and state types of the dual GPIO port block.
// Function
// - Port A output-capable data latch bits are read/write; reset leaves them unchanged.
// - Port A data bit 2 is read-only and returns the live pin level.
// - Direction bit 1 enables the pin output driver; 0 disables it.
// - Reset clears all six port A direction bits; pins start as inputs.
// - Data latches of both ports accept writes whatever the direction bit.
// - A write to an input pin's latch stores only; pin readback is unaffected.
// - A pullup is switched off whenever its pin's direction selects output.
// - Port A pullup enable 1 connects pullup on inputs; 0 keeps it off.
// - Internal or RC option with clock-out enable drives quad bus clock on bit 4.
// - The clock-out enable has no effect under crystal or external clock option.
// - Port A bit 2 never drives an output, even with direction set.
// - Each port A pin also feeds the keypad interrupt, gated by outside enables; the code holds bit 4 off while it drives the clock-out.
// - All eight port B latch bits are read/write; reset leaves them unchanged.
// - Reset clears all eight port B direction bits; pins start as inputs.
// - Port B pullup enable 1 connects pullup on inputs; 0 keeps it off.
// - With the external interrupt function enabled, port A data bit 2 reads 0.
package dgp_pkg;

	// ------------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [3:0] IDX_PA = 4'h0;
	localparam logic [3:0] IDX_PB = 4'h1;
	localparam logic [3:0] IDX_DIR_A = 4'h2;
	localparam logic [3:0] IDX_DIR_B = 4'h3;
	localparam logic [3:0] IDX_PUE_A = 4'h4;
	localparam logic [3:0] IDX_PUE_B = 4'h5;
	localparam logic [3:0] IDX_CFG = 4'h6;

	// ------------------------------------------------------------------
	// Fields, masks and reset values.
	// ------------------------------------------------------------------
	localparam logic [5:0] PA_DATA_MASK = 6'h3B;
	localparam int PA_IN_ONLY_BIT = 2;
	localparam int PA_SHARED_BIT = 4;
	localparam int OSC_EN_BIT = 7;
	localparam int CFG_IRQ_BIT = 2;
	localparam logic [1:0] OSC_INT = 2'h0;
	localparam logic [1:0] OSC_EXT = 2'h1;
	localparam logic [1:0] OSC_RC = 2'h2;
	localparam logic [1:0] OSC_XTAL = 2'h3;
	localparam logic [5:0] DIR_A_RST = 6'h00;
	localparam logic [7:0] DIR_B_RST = 8'h00;
	localparam logic [5:0] PUE_A_RST = 6'h00;
	localparam logic [7:0] PUE_B_RST = 8'h00;
	localparam logic [1:0] CFG_OSC_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// State types.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [5:0] dir_a;
		logic [7:0] dir_b;
		logic [5:0] pue_a;
		logic osc_en;
		logic [7:0] pue_b;
		logic [1:0] cfg_osc;
		logic cfg_irq;
		logic [5:0] sa1;
		logic [5:0] sa2;
		logic [7:0] sb1;
		logic [7:0] sb2;
		logic qc1;
		logic qc2;
		logic aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [5:0] pa_out;
		logic [5:0] pa_oe;
		logic [5:0] pa_pu;
		logic [7:0] pb_out;
		logic [7:0] pb_oe;
		logic [7:0] pb_pu;
		logic [5:0] keypad_interrupt;
	} dgp_ctl_s;

	typedef struct packed {
		logic [5:0] lat_a;
		logic [7:0] lat_b;
	} dgp_lat_s;

endpackage : dgp_pkg

// ### test/dgp_pin_model.sv
// Behavioural model of the circuitry hanging on one port's pins.
`timescale 1ns/100ps
module dgp_pin_model #(
	parameter int W = 8
) (
	input wire logic mclk_i,
	input wire logic [W-1:0] out_i,
	input wire logic [W-1:0] oe_i,
	input wire logic [W-1:0] pu_i,
	input wire logic [W-1:0] ext_i,
	input wire logic [W-1:0] ext_en_i,
	output logic [W-1:0] pin_o
);
	// A floating pin toggles every cycle, so a missing pullup never reads as a lucky constant.
	logic [W-1:0] flt = '0;
	always @(posedge mclk_i) flt <= ~flt;
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_o[i] = oe_i[i] ? out_i[i] : (ext_en_i[i] ? ext_i[i] : (pu_i[i] ? 1'b1 : flt[i]));
		end
	end
endmodule : dgp_pin_model

// ### test/testbench.sv
// Self-checking testbench of the dual GPIO port block.
`timescale 1ns/100ps
module testbench;
	import dgp_pkg::*;
	typedef struct packed {logic [7:0] a; logic [31:0] v; logic [31:0] e; logic [1:0] r;} dgp_row_s;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, quad = 1'b0, k;
	logic [7:0] awa = 8'h00, ara = 8'h00, ext_b = 8'h00, en_b = 8'h00, pb_out, pb_oe, pb_pu, pb_pin;
	logic [31:0] wd = 32'h0, rdata, d;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] bresp, rresp, r;
	logic [5:0] ext_a = 6'h00, en_a = 6'h00, kbe = 6'h00, keypad_interrupt, pa_out, pa_oe, pa_pu, pa_pin;
	logic [3:0] ws = 4'hF;
	int fails = 0;
	int n_tests = 0;
	dgp_row_s rows [11] = '{'{8'h08, 32'hFF, 32'h3F, RESP_OKAY}, '{8'h0C, 32'hA5, 32'hA5, RESP_OKAY},
		'{8'h10, 32'hFF, 32'hBF, RESP_OKAY}, '{8'h14, 32'h5A, 32'h5A, RESP_OKAY}, '{8'h18, 32'hFF, 32'h07, RESP_OKAY},
		'{8'h1C, 32'h11, 32'h0, RESP_SLVERR}, '{8'h0A, 32'h11, 32'h0, RESP_SLVERR}, '{8'h10, 32'h0, 32'h0, RESP_OKAY},
		'{8'h18, 32'h0, 32'h0, RESP_OKAY}, '{8'h0C, 32'h0, 32'h0, RESP_OKAY}, '{8'h08, 32'h0, 32'h0, RESP_OKAY}};

	dgp_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.pa_in_i(pa_pin), .pa_out_o(pa_out), .pa_oe_o(pa_oe), .pa_pullup_o(pa_pu), .pb_in_i(pb_pin),
		.pb_out_o(pb_out), .pb_oe_o(pb_oe), .pb_pullup_o(pb_pu), .quad_bus_clock_i(quad),
		.keypad_irq_enables_i(kbe), .keypad_interrupt_o(keypad_interrupt));
	dgp_pin_model #(.W(6)) PMA (.mclk_i(mclk_i), .out_i(pa_out), .oe_i(pa_oe), .pu_i(pa_pu), .ext_i(ext_a),
		.ext_en_i(en_a), .pin_o(pa_pin));
	dgp_pin_model #(.W(8)) PMB (.mclk_i(mclk_i), .out_i(pb_out), .oe_i(pb_oe), .pu_i(pb_pu), .ext_i(ext_b),
		.ext_en_i(en_b), .pin_o(pb_pin));

	initial begin
		forever #50 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------------------------
	// Bus tasks and comparisons.
	// ------------------------------------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t value %h expected %h", $time, g, e);
		end
	endtask : cmp

	task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t response %h expected %h", $time, g, e);
		end
	endtask : cmp_resp

	// Ready is looked at on the falling edge, where it is settled, and acted on at the next rising edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, th;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		awa <= a;
		wd <= v;
		th = 1'b0;
		while (!th) begin
			@(negedge mclk_i);
			ta = awv & awr;
			tw = wv & wrd;
			th = bv & br;
			r = bresp;
			@(posedge mclk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		// Bready stays high between writes, so two writes in a row never drop and raise it in one step.
	endtask : wr

	// Pin levels pass a two-flop synchroniser, so a read first lets three edges go by.
	task automatic rd(input logic [7:0] a);
		logic ta, th;
		repeat (3) @(posedge mclk_i);
		arv <= 1'b1;
		rr <= 1'b1;
		ara <= a;
		th = 1'b0;
		while (!th) begin
			@(negedge mclk_i);
			ta = arv & arr;
			th = rv & rr;
			d = rdata;
			r = rresp;
			@(posedge mclk_i);
			if (ta) arv <= 1'b0;
		end
		rr <= 1'b0;
	endtask : rd

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		cmp(d, e);
		cmp_resp(r, RESP_OKAY);
	endtask : chk

	task automatic do_reset();
		rst_b_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask : do_reset

	task automatic print_verdict();
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------
	initial begin
		do_reset();
		chk(8'h08, 32'h0);
		chk(8'h0C, 32'h0);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].v);
			cmp_resp(r, rows[i].r);
			rd(rows[i].a);
			cmp(d, rows[i].e);
			cmp_resp(r, rows[i].r);
		end
		en_a <= 6'h3F;
		en_b <= 8'hFF;
		ext_a <= 6'h2A;
		ext_b <= 8'h3C;
		wr(8'h00, 32'h15);
		chk(8'h00, 32'h2A);
		ext_a <= 6'h04;
		wr(8'h08, 32'h3F);
		chk(8'h00, 32'h15);
		wr(8'h18, 32'h04);
		chk(8'h00, 32'h11);
		@(negedge mclk_i);
		cmp(pa_oe, 6'h3B);
		cmp(pa_out, 6'h11);
		@(posedge mclk_i);
		wr(8'h18, 32'h0);
		wr(8'h10, 32'h3F);
		wr(8'h08, 32'h0F);
		@(negedge mclk_i);
		cmp(pa_pu, 6'h30);
		@(posedge mclk_i);
		wr(8'h04, 32'hA5);
		wr(8'h0C, 32'hF0);
		wr(8'h14, 32'hFF);
		chk(8'h04, 32'hAC);
		cmp(pb_out, 8'hA0);
		cmp(pb_oe, 8'hF0);
		cmp(pb_pu, 8'h0F);
		ws <= 4'h0;
		wr(8'h04, 32'h5A);
		cmp_resp(r, RESP_OKAY);
		ws <= 4'hF;
		chk(8'h04, 32'hAC);
		wr(8'h08, 32'h0);
		ext_a <= 6'h3F;
		kbe <= 6'h3D;
		quad <= 1'b1;
		wr(8'h10, 32'h80);
		// Every clock option in turn; only internal and RC let the clock out.
		for (int i = 0; i < 4; i++) begin
			wr(8'h18, i);
			repeat (4) @(posedge mclk_i);
			@(negedge mclk_i);
			k = (i == 0 || i == 2);
			cmp(pa_oe[4], k);
			cmp(pa_out[4], k);
			cmp(keypad_interrupt, {1'b1, ~k, 4'hD});
			@(posedge mclk_i);
		end
		wr(8'h18, 32'h2);
		quad <= 1'b0;
		repeat (4) @(posedge mclk_i);
		cmp(pa_out[4], 1'b0);
		do_reset();
		cmp(pa_oe, 6'h00);
		cmp(pb_oe, 8'h00);
		wr(8'h0C, 32'hFF);
		chk(8'h04, 32'hA5);
		wr(8'h08, 32'h3F);
		chk(8'h00, 32'h15);
		print_verdict();
	end

	initial begin
		#3000000;
		fails++;
		print_verdict();
	end
endmodule : testbench
